// >>> bench/aax_rf_model.sv
// register file and flag byte model facing the execution datapath
module aax_rf_model (
  input  wire logic       clk,
  input  wire logic [7:0] rfAddr,
  output logic [7:0]      rfRdData,
  input  wire logic       rfWe,
  input  wire logic [7:0] rfWrData,
  input  wire logic       flagsWe,
  input  wire logic [7:0] flagsOut,
  output logic [7:0]      flagReg
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] mem [256];

  // ----
  // storage
  // ----
  // same-cycle read; an unknown address gives unknown data, no kinder
  assign rfRdData = mem[rfAddr];

  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'h5a;
    end
    flagReg = 8'h00;
  end

  always @(posedge clk) begin
    if (rfWe) begin
      mem[rfAddr] <= rfWrData;
    end
    if (flagsWe) begin
      flagReg <= flagsOut;
    end
  end
endmodule

// >>> bench/test_add_adc_and_alu_ops.sv
// self-checking bench of the add, add-with-carry and and datapath
module test_add_adc_and_alu_ops;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clk;
  logic       rstn;
  logic       start;
  logic [7:0] opcode;
  logic [7:0] opByte2;
  logic [7:0] opByte3;
  logic [7:0] regPtr;
  logic [7:0] flagsIn;
  logic [7:0] rfRdData;
  logic       busy;
  logic       done;
  logic       badOp;
  logic [7:0] rfAddr;
  logic       rfWe;
  logic [7:0] rfWrData;
  logic       flagsWe;
  logic [7:0] flagsOut;
  int         num_errors;
  int         tests_run;

  aax_exec i_dut (.clk(clk), .rstn(rstn), .start(start), .opcode(opcode),
    .opByte2(opByte2), .opByte3(opByte3), .regPtr(regPtr), .flagsIn(flagsIn),
    .rfRdData(rfRdData), .busy(busy), .done(done), .badOp(badOp), .rfAddr(rfAddr),
    .rfWe(rfWe), .rfWrData(rfWrData), .flagsWe(flagsWe), .flagsOut(flagsOut));

  aax_rf_model i_rf (.clk(clk), .rfAddr(rfAddr), .rfRdData(rfRdData), .rfWe(rfWe),
    .rfWrData(rfWrData), .flagsWe(flagsWe), .flagsOut(flagsOut), .flagReg(flagsIn));

  always #10 clk = ~clk;

  // ----
  // helpers
  // ----
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected value at %0d ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic put(input logic [7:0] ad, input logic [7:0] v);
    i_rf.mem[ad] = v;
  endtask

  // one instruction: expectation from operands, then timing, write and flags
  task automatic exec_op(input logic [7:0] opc, b2, b3, rp, fin, dA, sA,
                         input bit srcReg, input bit poke);
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] r;
    logic [7:0] nf;
    logic       cin;
    logic [8:0] s;
    logic [4:0] h;
    int         k;
    a = i_rf.mem[dA];
    b = srcReg ? i_rf.mem[sA] : b3;
    cin = (opc[7:4] == 4'h1) & fin[7];
    s = a + b + cin;
    h = a[3:0] + b[3:0] + cin;
    if (opc[6]) begin
      r = a & b;
      nf = {fin[7], r == 8'h00, r[7], 1'b0, fin[3:0]};
    end else begin
      r = s[7:0];
      nf = {s[8], r == 8'h00, r[7], a[7] == b[7] && r[7] != a[7], 1'b0, h[4], fin[1:0]};
    end
    i_rf.flagReg = fin;
    {opcode, opByte2, opByte3, regPtr} = {opc, b2, b3, rp};
    start = 1'b1;
    @(posedge clk);
    #1;
    // a second request while busy must be ignored
    start = poke;
    k = 1;
    while (done !== 1'b1) begin
      check({4'h0, busy, rfWe, flagsWe, badOp}, 8'h08);
      if (k == 2)
        start = 1'b0;
      @(posedge clk);
      #1;
      k++;
      if (k > 12) begin
        num_errors++;
        $display("unexpected hang at %0d ns: done %h expected 1", $time, done);
        finish_test();
      end
    end
    check(8'(k), (opc[3:0] < 4'h4) ? 8'h05 : 8'h09);
    check({5'h0, rfWe, flagsWe, busy}, 8'h07);
    check(rfAddr, dA);
    check(rfWrData, r);
    check(flagsOut, nf);
    @(posedge clk);
    #1;
    check({7'h0, busy}, 8'h00);
    check(i_rf.mem[dA], r);
    if (srcReg)
      check(i_rf.mem[sA], b);
    check(i_rf.flagReg, nf);
  endtask

  // ----
  // scenarios
  // ----
  task automatic test_reset();
    check({3'h0, busy, done, badOp, rfWe, flagsWe}, 8'h00);
    check(rfAddr, 8'h00);
    check(rfWrData, 8'h00);
    check(flagsOut, 8'h00);
    @(posedge clk);
    #1;
  endtask

  // two-byte forms in working register group 1x, back to back
  task automatic test_short();
    put(8'h13, 8'h16);
    put(8'h1b, 8'h20);
    exec_op(8'h02, 8'h3b, 8'h00, 8'h10, 8'h00, 8'h13, 8'h1b, 1, 1);
    put(8'h13, 8'h16);
    exec_op(8'h12, 8'h3b, 8'h00, 8'h10, 8'h80, 8'h13, 8'h1b, 1, 0);
    put(8'h1f, 8'h16);
    put(8'h1a, 8'h20);
    put(8'h20, 8'h11);
    exec_op(8'h03, 8'hfa, 8'h00, 8'h10, 8'h00, 8'h1f, 8'h20, 1, 0);
    put(8'h1f, 8'h16);
    exec_op(8'h13, 8'hfa, 8'h00, 8'h10, 8'h80, 8'h1f, 8'h20, 1, 0);
    put(8'h11, 8'h34);
    put(8'h1e, 8'h4d);
    exec_op(8'h52, 8'h1e, 8'h00, 8'h10, 8'hff, 8'h11, 8'h1e, 1, 1);
    put(8'h14, 8'hf9);
    put(8'h1d, 8'h7b);
    put(8'h7b, 8'h6a);
    exec_op(8'h53, 8'h4d, 8'h00, 8'h10, 8'h00, 8'h14, 8'h7b, 1, 0);
  endtask

  // three-byte forms: register, indirect source, immediate, indirect dst
  task automatic test_long();
    put(8'h34, 8'h2e);
    put(8'h12, 8'h1b);
    exec_op(8'h04, 8'h12, 8'h34, 8'h00, 8'h00, 8'h34, 8'h12, 1, 0);
    put(8'h34, 8'h2e);
    exec_op(8'h14, 8'h12, 8'h34, 8'h00, 8'h80, 8'h34, 8'h12, 1, 0);
    put(8'h3a, 8'hf5);
    put(8'h42, 8'h0a);
    exec_op(8'h54, 8'h42, 8'h3a, 8'h00, 8'h00, 8'h3a, 8'h42, 1, 0);
    put(8'h4b, 8'h82);
    put(8'h03, 8'h10);
    put(8'h10, 8'h01);
    exec_op(8'h05, 8'he3, 8'h4b, 8'h00, 8'h00, 8'h4b, 8'h10, 1, 0);
    put(8'h4b, 8'h82);
    exec_op(8'h15, 8'he3, 8'h4b, 8'h00, 8'h80, 8'h4b, 8'h10, 1, 0);
    put(8'h05, 8'hf0);
    put(8'h45, 8'h3a);
    put(8'h3a, 8'h7f);
    exec_op(8'h55, 8'h45, 8'he5, 8'h00, 8'h00, 8'h05, 8'h3a, 1, 0);
    put(8'h6c, 8'h2a);
    exec_op(8'h06, 8'h6c, 8'h03, 8'h00, 8'h00, 8'h6c, 8'h00, 0, 0);
    exec_op(8'h16, 8'h6c, 8'hff, 8'h00, 8'h80, 8'h6c, 8'h00, 0, 0);
    put(8'h7a, 8'hf7);
    exec_op(8'h56, 8'h7a, 8'hf0, 8'h00, 8'h00, 8'h7a, 8'h00, 0, 0);
    put(8'hd4, 8'h5f);
    put(8'h5f, 8'h4c);
    exec_op(8'h07, 8'hd4, 8'h02, 8'h00, 8'h00, 8'h5f, 8'h00, 0, 0);
    exec_op(8'h17, 8'hd4, 8'h02, 8'h00, 8'h80, 8'h5f, 8'h00, 0, 0);
    put(8'h03, 8'h3e);
    put(8'h3e, 8'hec);
    exec_op(8'h57, 8'he3, 8'h05, 8'h00, 8'h00, 8'h3e, 8'h00, 0, 0);
  endtask

  // flag corners through working registers of group 3x
  task automatic edge_op(input logic [7:0] opc, d, s, fin);
    put(8'h32, d);
    put(8'h35, s);
    exec_op(opc, 8'he5, 8'he2, 8'h30, fin, 8'h32, 8'h35, 1, 0);
  endtask

  task automatic test_edges();
    edge_op(8'h04, 8'h7f, 8'h01, 8'h00);
    edge_op(8'h04, 8'hff, 8'h01, 8'h0f);
    edge_op(8'h14, 8'hff, 8'h00, 8'h80);
    edge_op(8'h04, 8'h80, 8'h80, 8'h00);
    edge_op(8'h14, 8'h01, 8'h01, 8'h7f);
    edge_op(8'h54, 8'h0f, 8'hf0, 8'hff);
    edge_op(8'h54, 8'h8f, 8'hf0, 8'h1c);
    exec_op(8'h06, 8'he2, 8'h01, 8'h30, 8'h00, 8'h32, 8'h00, 0, 0);
  endtask

  // undecodable opcodes: a single error pulse, no write
  task automatic test_bad_op();
    logic [7:0] bad [4] = '{8'h08, 8'h22, 8'h51, 8'h61};
    foreach (bad[i]) begin
      opcode = bad[i];
      start = 1'b1;
      @(posedge clk);
      #1;
      start = 1'b0;
      check({4'h0, badOp, busy, rfWe, flagsWe}, 8'h08);
      @(posedge clk);
      #1;
      check({4'h0, badOp, busy, rfWe, flagsWe}, 8'h00);
    end
  endtask

  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    start = 1'b0;
    {opcode, opByte2, opByte3, regPtr} = 32'h0;
    num_errors = 0;
    tests_run = 0;
    repeat (2) @(posedge clk);
    #1;
    rstn = 1'b1;
    test_reset();
    test_short();
    test_long();
    test_edges();
    test_bad_op();
    finish_test();
  end
endmodule

// >>> design/aax_alu.sv
// add, add-with-carry and and, with flag byte update
module aax_alu import aax_pkg::*; (
  aax_alu_if.alu bus
);
  logic [8:0] sum;
  logic [4:0] half;
  logic [7:0] res;
  logic [7:0] fl;
  logic       cin;

  always_comb begin
    cin  = (bus.op == AAX_OP_ADC) ? bus.flagsIn[FLG_C] : 1'b0;
    sum  = 9'h000;
    half = 5'h00;
    res  = RST_BYTE;
    fl   = bus.flagsIn;
    case (bus.op)
      AAX_OP_ADD, AAX_OP_ADC: begin
        sum       = {1'b0, bus.a} + {1'b0, bus.b} + {8'h00, cin};
        half      = {1'b0, bus.a[3:0]} + {1'b0, bus.b[3:0]} + {4'h0, cin};
        res       = sum[7:0];
        fl[FLG_C] = sum[8];
        fl[FLG_Z] = (res == 8'h00);
        fl[FLG_S] = res[7];
        fl[FLG_V] = (bus.a[7] == bus.b[7]) && (res[7] != bus.a[7]);
        fl[FLG_D] = 1'b0;
        fl[FLG_H] = half[4];
      end
      AAX_OP_AND: begin
        res       = bus.a & bus.b;
        fl[FLG_Z] = (res == 8'h00);
        fl[FLG_S] = res[7];
        fl[FLG_V] = 1'b0;
      end
      default: res = RST_BYTE;
    endcase
  end

  assign bus.result   = res;
  assign bus.flagsOut = fl;
endmodule

// >>> design/aax_alu_if.sv
// operand and result bundle between the sequencer and the arithmetic unit
interface aax_alu_if;
  import aax_pkg::*;
  aax_op_t    op;
  logic [7:0] a;
  logic [7:0] b;
  logic [7:0] flagsIn;
  logic [7:0] result;
  logic [7:0] flagsOut;

  modport core (output op, a, b, flagsIn, input result, flagsOut);
  modport alu  (input op, a, b, flagsIn, output result, flagsOut);
endinterface

// >>> design/aax_decode.sv
// opcode and operand byte decode into addresses, form and cycle count
module aax_decode import aax_pkg::*; (
  input  wire logic [7:0] opcode,
  input  wire logic [7:0] opByte2,
  input  wire logic [7:0] opByte3,
  input  wire logic [7:0] regPtr,
  output aax_op_t         op,
  output logic            valid,
  output logic            srcImm,
  output logic            srcInd,
  output logic            dstInd,
  output logic [7:0]      srcAddr,
  output logic [7:0]      dstAddr,
  output logic [7:0]      immVal,
  output logic [3:0]      cycles
);
  logic opOk;

  always_comb begin
    opOk    = 1'b1;
    op      = AAX_OP_ADD;
    valid   = 1'b1;
    srcImm  = 1'b0;
    srcInd  = 1'b0;
    dstInd  = 1'b0;
    srcAddr = RST_BYTE;
    dstAddr = RST_BYTE;
    immVal  = opByte3;
    cycles  = CYC_LONG;
    case (opcode[7:4])
      OPH_ADD: op = AAX_OP_ADD;
      OPH_ADC: op = AAX_OP_ADC;
      OPH_AND: op = AAX_OP_AND;
      default: opOk = 1'b0;
    endcase
    case (opcode[3:0])
      FORM_RR, FORM_RIR: begin
        // dst number in the high nibble, src in the low one
        dstAddr = aax_wr_addr(regPtr, opByte2[7:4]);
        srcAddr = aax_wr_addr(regPtr, opByte2[3:0]);
        srcInd  = (opcode[3:0] == FORM_RIR);
        cycles  = CYC_SHORT;
      end
      FORM_R_R, FORM_R_IR: begin
        srcAddr = aax_reg_addr(regPtr, opByte2);
        dstAddr = aax_reg_addr(regPtr, opByte3);
        srcInd  = (opcode[3:0] == FORM_R_IR);
      end
      FORM_R_IM, FORM_IR_IM: begin
        dstAddr = aax_reg_addr(regPtr, opByte2);
        srcImm  = 1'b1;
        dstInd  = (opcode[3:0] == FORM_IR_IM);
      end
      default: valid = 1'b0;
    endcase
    valid = valid & opOk;
  end
endmodule

// >>> design/aax_exec.sv
// execution sequencer for add, add-with-carry and logical and
module aax_exec import aax_pkg::*; (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       start,
  input  wire logic [7:0] opcode,
  input  wire logic [7:0] opByte2,
  input  wire logic [7:0] opByte3,
  input  wire logic [7:0] regPtr,
  input  wire logic [7:0] flagsIn,
  input  wire logic [7:0] rfRdData,
  output logic            busy,
  output logic            done,
  output logic            badOp,
  output logic [7:0]      rfAddr,
  output logic            rfWe,
  output logic [7:0]      rfWrData,
  output logic            flagsWe,
  output logic [7:0]      flagsOut
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    aax_state_t state;
    logic [3:0] cnt;
    logic [3:0] cycles;
    aax_op_t    op;
    logic       dstInd;
    logic [7:0] dstA;
    logic [7:0] srcV;
    logic [7:0] dstV;
    logic [7:0] flg;
    logic [7:0] rfAddr;
    logic       rfWe;
    logic [7:0] rfWrData;
    logic       flagsWe;
    logic [7:0] flagsOut;
    logic       done;
    logic       badOp;
  } aax_regs_t;

  aax_regs_t s;
  aax_regs_t next_s;

  // ----------------------------------------------------------------
  // decode and arithmetic
  // ----------------------------------------------------------------
  aax_op_t    decOp;
  logic       decValid;
  logic       decSrcImm;
  logic       decSrcInd;
  logic       decDstInd;
  logic [7:0] decSrcA;
  logic [7:0] decDstA;
  logic [7:0] decImm;
  logic [3:0] decCycles;
  logic       take;

  aax_alu_if aluBus ();

  aax_decode uDecode (
    .opcode  (opcode),
    .opByte2 (opByte2),
    .opByte3 (opByte3),
    .regPtr  (regPtr),
    .op      (decOp),
    .valid   (decValid),
    .srcImm  (decSrcImm),
    .srcInd  (decSrcInd),
    .dstInd  (decDstInd),
    .srcAddr (decSrcA),
    .dstAddr (decDstA),
    .immVal  (decImm),
    .cycles  (decCycles)
  );

  aax_alu uAlu (
    .bus (aluBus.alu)
  );

  // operands sit in flops from the read phase on, so the alu result is
  // steady through wait and write-back
  assign aluBus.op      = s.op;
  assign aluBus.a       = s.dstV;
  assign aluBus.b       = s.srcV;
  assign aluBus.flagsIn = s.flg;

  assign take = start && (s.state == ST_IDLE) && decValid;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_s         = s;
    next_s.rfWe    = 1'b0;
    next_s.flagsWe = 1'b0;
    next_s.done    = 1'b0;
    next_s.badOp   = 1'b0;
    if (s.state != ST_IDLE) begin
      next_s.cnt = s.cnt + 4'h1;
    end
    case (s.state)
      ST_IDLE: begin
        if (start && !decValid) begin
          next_s.badOp = 1'b1;
        end else if (take) begin
          next_s.op     = decOp;
          next_s.cycles = decCycles;
          next_s.dstInd = decDstInd;
          next_s.dstA   = decDstA;
          // flags sampled once so a carry-in cannot shift mid-instruction
          next_s.flg    = flagsIn;
          next_s.cnt    = CNT_FIRST;
          if (decSrcImm) begin
            next_s.srcV   = decImm;
            next_s.rfAddr = decDstA;
            next_s.state  = decDstInd ? ST_DPTR : ST_DST;
          end else begin
            next_s.rfAddr = decSrcA;
            next_s.state  = decSrcInd ? ST_SPTR : ST_SRC;
          end
        end
      end
      ST_SPTR: begin
        // pointer content is a full register address, no remap
        next_s.rfAddr = rfRdData;
        next_s.state  = ST_SRC;
      end
      ST_SRC: begin
        next_s.srcV   = rfRdData;
        next_s.rfAddr = s.dstA;
        next_s.state  = s.dstInd ? ST_DPTR : ST_DST;
      end
      ST_DPTR: begin
        next_s.dstA   = rfRdData;
        next_s.rfAddr = rfRdData;
        next_s.state  = ST_DST;
      end
      ST_DST: begin
        next_s.dstV  = rfRdData;
        next_s.state = ST_WAIT;
      end
      ST_WAIT: begin
        if (s.cnt == s.cycles - 4'h1) begin
          next_s.state    = ST_WB;
          next_s.rfAddr   = s.dstA;
          next_s.rfWe     = 1'b1;
          next_s.rfWrData = aluBus.result;
          next_s.flagsWe  = 1'b1;
          next_s.flagsOut = aluBus.flagsOut;
          next_s.done     = 1'b1;
        end
      end
      ST_WB: begin
        next_s.state = ST_IDLE;
        next_s.cnt   = RST_CNT;
      end
      default: begin
        next_s = '0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign busy     = (s.state != ST_IDLE);
  assign done     = s.done;
  assign badOp    = s.badOp;
  assign rfAddr   = s.rfAddr;
  assign rfWe     = s.rfWe;
  assign rfWrData = s.rfWrData;
  assign flagsWe  = s.flagsWe;
  assign flagsOut = s.flagsOut;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [8:0] chkSum;
  logic [4:0] chkHalf;
  logic       chkCin;

  assign chkCin  = (s.op == AAX_OP_ADC) ? s.flg[FLG_C] : 1'b0;
  assign chkSum  = {1'b0, s.dstV} + {1'b0, s.srcV} + {8'h00, chkCin};
  assign chkHalf = {1'b0, s.dstV[3:0]} + {1'b0, s.srcV[3:0]} + {4'h0, chkCin};

  chk_add_sum: assert property (@(posedge clk) disable iff (!rstn)
    (rfWe && s.op == AAX_OP_ADD) |-> rfWrData == 8'(s.dstV + s.srcV))
    else $error("add result wrong");

  chk_adc_sum: assert property (@(posedge clk) disable iff (!rstn)
    (rfWe && s.op == AAX_OP_ADC) |-> rfWrData == 8'(s.dstV + s.srcV + {7'h00, s.flg[FLG_C]}))
    else $error("add-with-carry result wrong");

  chk_carry_out: assert property (@(posedge clk) disable iff (!rstn)
    (flagsWe && s.op != AAX_OP_AND) |-> flagsOut[FLG_C] == chkSum[8])
    else $error("carry flag wrong");

  chk_zero_flag: assert property (@(posedge clk) disable iff (!rstn)
    flagsWe |-> flagsOut[FLG_Z] == (rfWrData == 8'h00))
    else $error("zero flag wrong");

  chk_sign_add: assert property (@(posedge clk) disable iff (!rstn)
    (flagsWe && s.op != AAX_OP_AND) |-> flagsOut[FLG_S] == rfWrData[7])
    else $error("sign flag wrong after add");

  chk_ovf_add: assert property (@(posedge clk) disable iff (!rstn)
    (flagsWe && s.op != AAX_OP_AND) |->
      flagsOut[FLG_V] == ((s.dstV[7] == s.srcV[7]) && (rfWrData[7] != s.dstV[7])))
    else $error("overflow flag wrong");

  chk_half_dec: assert property (@(posedge clk) disable iff (!rstn)
    (flagsWe && s.op != AAX_OP_AND) |-> (flagsOut[FLG_H] == chkHalf[4]) && !flagsOut[FLG_D])
    else $error("half-carry or decimal flag wrong");

  chk_and_res: assert property (@(posedge clk) disable iff (!rstn)
    (rfWe && s.op == AAX_OP_AND) |-> rfWrData == (s.dstV & s.srcV))
    else $error("and result wrong");

  chk_and_keep: assert property (@(posedge clk) disable iff (!rstn)
    (flagsWe && s.op == AAX_OP_AND) |-> !flagsOut[FLG_V] && flagsOut[FLG_C] == s.flg[FLG_C]
      && flagsOut[FLG_D] == s.flg[FLG_D] && flagsOut[FLG_H] == s.flg[FLG_H])
    else $error("and disturbed kept flags");

  chk_and_sign: assert property (@(posedge clk) disable iff (!rstn)
    (flagsWe && s.op == AAX_OP_AND) |-> flagsOut[FLG_S] == rfWrData[7])
    else $error("sign flag wrong after and");

  chk_wr_field: assert property (@(posedge clk) disable iff (!rstn)
    (take && opcode[3:0] == FORM_R_IM && opByte2[7:4] == WR_PREFIX) |->
      ##1 s.dstA == {$past(regPtr[7:4]), $past(opByte2[3:0])})
    else $error("working register field not remapped");

  chk_short_time: assert property (@(posedge clk) disable iff (!rstn)
    (take && (opcode[3:0] == FORM_RR || opcode[3:0] == FORM_RIR)) |->
      !rfWe [*5] ##1 rfWe)
    else $error("short form not finished in 6 cycles");

  chk_long_time: assert property (@(posedge clk) disable iff (!rstn)
    (take && opcode[3:0] >= FORM_R_R) |-> ##9 (rfWe && flagsWe))
    else $error("long form not finished in 10 cycles");

  chk_src_ptr: assert property (@(posedge clk) disable iff (!rstn)
    (s.state == ST_SPTR) |=> (rfAddr == $past(rfRdData)) && s.state == ST_SRC)
    else $error("indirect source not followed");

  chk_dst_ptr: assert property (@(posedge clk) disable iff (!rstn)
    (s.state == ST_DPTR) |=> (s.dstA == $past(rfRdData)) && (rfAddr == $past(rfRdData)))
    else $error("indirect destination not followed");

  chk_joint_wb: assert property (@(posedge clk) disable iff (!rstn)
    ((rfWe == flagsWe) && (rfWe == done) && (!rfWe || rfAddr == s.dstA))
      and (rfWe |=> !busy))
    else $error("result and flags not written together");

  // write data and flag byte must hold between writes, the register file may latch late
  chk_data_hold: assert property (@(posedge clk) disable iff (!rstn)
    !rfWe |-> $stable(rfWrData))
    else $error("result changed without a write");

  chk_flag_hold: assert property (@(posedge clk) disable iff (!rstn)
    !flagsWe |-> $stable(flagsOut))
    else $error("flag byte changed without a write");

  chk_idle_quiet: assert property (@(posedge clk) disable iff (!rstn)
    !busy |-> !rfWe && !flagsWe && !done)
    else $error("write strobe while idle");

  chk_low_flags: assert property (@(posedge clk) disable iff (!rstn)
    flagsWe |-> flagsOut[1:0] == s.flg[1:0])
    else $error("unused flag bits disturbed");

  chk_take_busy: assert property (@(posedge clk) disable iff (!rstn)
    take |=> busy && !done && !badOp)
    else $error("taken request did not start");

  chk_bad_pulse: assert property (@(posedge clk) disable iff (!rstn)
    (start && !busy && !decValid) |=> badOp && !busy)
    else $error("bad opcode not flagged");

  chk_busy_ignore: assert property (@(posedge clk) disable iff (!rstn)
    (start && busy) |=> !badOp)
    else $error("request while busy not ignored");

  chk_short_count: assert property (@(posedge clk) disable iff (!rstn)
    (take && opcode[3:0] < FORM_R_R) |=> s.cycles == CYC_SHORT)
    else $error("short form cycle count wrong");

  chk_long_count: assert property (@(posedge clk) disable iff (!rstn)
    (take && opcode[3:0] >= FORM_R_R) |=> s.cycles == CYC_LONG)
    else $error("long form cycle count wrong");

  chk_imm_src: assert property (@(posedge clk) disable iff (!rstn)
    (take && opcode[3:0] >= FORM_R_IM) |=> s.srcV == $past(opByte3))
    else $error("immediate operand not taken");

  chk_adc_op: assert property (@(posedge clk) disable iff (!rstn)
    (take && opcode[7:4] == OPH_ADC) |=> s.op == AAX_OP_ADC)
    else $error("add-with-carry not selected");

  chk_src_read: assert property (@(posedge clk) disable iff (!rstn)
    (s.state == ST_SRC) |=> (s.srcV == $past(rfRdData)) && (rfAddr == s.dstA))
    else $error("source operand not read");

  chk_dst_read: assert property (@(posedge clk) disable iff (!rstn)
    (s.state == ST_DST) |=> (s.dstV == $past(rfRdData)) && s.state == ST_WAIT)
    else $error("destination operand not read");

  chk_wb_return: assert property (@(posedge clk) disable iff (!rstn)
    (s.state == ST_WB) |=> s.state == ST_IDLE)
    else $error("no return to idle after write-back");

endmodule

// >>> design/aax_pkg.sv
// shared constants, types and helpers of the add/adc/and execution datapath
package aax_pkg;

  // ----------------------------------------------------------------
  // opcode layout
  // ----------------------------------------------------------------
  localparam logic [3:0] OPH_ADD    = 4'h0;
  localparam logic [3:0] OPH_ADC    = 4'h1;
  localparam logic [3:0] OPH_AND    = 4'h5;
  localparam logic [3:0] FORM_RR    = 4'h2;
  localparam logic [3:0] FORM_RIR   = 4'h3;
  localparam logic [3:0] FORM_R_R   = 4'h4;
  localparam logic [3:0] FORM_R_IR  = 4'h5;
  localparam logic [3:0] FORM_R_IM  = 4'h6;
  localparam logic [3:0] FORM_IR_IM = 4'h7;
  localparam logic [3:0] WR_PREFIX  = 4'he;

  // ----------------------------------------------------------------
  // cycle counts and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] CYC_SHORT  = 4'h6;
  localparam logic [3:0] CYC_LONG   = 4'ha;
  localparam logic [3:0] CNT_FIRST  = 4'h2;
  localparam logic [3:0] RST_CNT    = 4'h0;
  localparam logic [7:0] RST_BYTE   = 8'h00;

  // ----------------------------------------------------------------
  // flag byte bit positions
  // ----------------------------------------------------------------
  localparam int FLG_C = 7;
  localparam int FLG_Z = 6;
  localparam int FLG_S = 5;
  localparam int FLG_V = 4;
  localparam int FLG_D = 3;
  localparam int FLG_H = 2;

  typedef enum logic [1:0] {
    AAX_OP_ADD = 2'b00,
    AAX_OP_ADC = 2'b01,
    AAX_OP_AND = 2'b10
  } aax_op_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SPTR = 3'b001,
    ST_SRC  = 3'b010,
    ST_DPTR = 3'b011,
    ST_DST  = 3'b100,
    ST_WAIT = 3'b101,
    ST_WB   = 3'b110
  } aax_state_t;

  // working register n lives in the 16-byte group picked by the pointer
  function automatic logic [7:0] aax_wr_addr(input logic [7:0] rp, input logic [3:0] n);
    return {rp[7:4], n};
  endfunction

  function automatic logic [7:0] aax_reg_addr(input logic [7:0] rp, input logic [7:0] f);
    return (f[7:4] == WR_PREFIX) ? aax_wr_addr(rp, f[3:0]) : f;
  endfunction

endpackage
